// [hdl/flrc_pkg.sv]
// Operation
// - Host waits at least 50 ns after clear release before a read.
// - Host may start its next cycle at once when done_flag_pin shows ready.
// - Host cycles select or output enable between successive status reads.
// - Protect: addr_bit6=0, addr_bit1=1, addr_bit0=0; unprotect sets addr_bit6=1.
// - Host holds clear at elevated_voltage_level 4 us before any write; here only after OP_HV_ON, and writes also go out with it off.
package flrc_pkg;
    localparam int T_CLK_NS     = 50;
    localparam int RDY_ALG_NS   = 20000;
    localparam int RDY_IDLE_NS  = 500;
    localparam int REL_READ_NS  = 50;
    localparam int HV_SETUP_NS  = 4000;
    localparam int BUSY_DLY_NS  = 90;
    localparam int RDY_ALG_CYC  = (RDY_ALG_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int RDY_IDLE_CYC = (RDY_IDLE_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int REL_READ_CYC = (REL_READ_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int HV_SETUP_CYC = (HV_SETUP_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int BUSY_DLY_CYC = (BUSY_DLY_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int TMR_W        = 10;

    localparam logic [4:0] REG_CTRL  = 5'h00;
    localparam logic [4:0] REG_ADDR  = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_STAT  = 5'h0C;
    localparam logic [4:0] REG_RDATA = 5'h10;

    localparam int CTRL_GO     = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_UNPROT = 4;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_READY  = 1;
    localparam int STAT_HV     = 2;
    localparam int STAT_SETTLE = 3;
    localparam int STAT_SUSTOG = 4;

    localparam int PROT_BIT6 = 6;
    localparam int PROT_BIT1 = 1;
    localparam int PROT_BIT0 = 0;
    localparam int TOG_BIT   = 6;
    localparam int SUS_BIT   = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        OP_READ   = 3'h0,
        OP_WRITE  = 3'h1,
        OP_PROG   = 3'h2,
        OP_CLEAR  = 3'h3,
        OP_POLL   = 3'h4,
        OP_HV_ON  = 3'h5,
        OP_HV_OFF = 3'h6,
        OP_PROT   = 3'h7
    } flrc_op_e;
endpackage

// [hdl/flrc_cycle.sv]
`timescale 1ns/1ps
`default_nettype none
module flrc_cycle import flrc_pkg::*; #(
    parameter int ADDR_W  = 20,
    parameter int ACC_CYC = 3,
    parameter int WP_CYC  = 1
) (
    // Clock, reset and enable
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Request
    input  wire logic              start_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    output logic                   done_o,
    output logic [7:0]             rdata_o,
    // Flash pins
    output logic                   flash_ce_n_o,
    output logic                   flash_oe_n_o,
    output logic                   flash_we_n_o,
    output logic [ADDR_W-1:0]      flash_addr_o,
    input  wire logic [7:0]        flash_dq_i,
    output logic [7:0]             flash_dq_o,
    output logic                   flash_dq_oe_o
);
    if (ACC_CYC < 1 || ACC_CYC > 15 || WP_CYC < 1 || WP_CYC > 15) begin : g_bad
        $error("flrc_cycle: strobe counts must be 1 to 15");
    end

    typedef enum logic [3:0] {
        C_IDLE  = 4'h1,
        C_SETUP = 4'h2,
        C_STRB  = 4'h4,
        C_END   = 4'h8
    } flrc_cst_e;

    flrc_cst_e  cst_q;
    logic [3:0] cnt_q;
    logic       wr_q;

    assign done_o = (cst_q == C_END);

    // Strobes always return high in C_END, so back-to-back status reads
    // see output enable cycle between them.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cst_q         <= C_IDLE;
            cnt_q         <= 4'h0;
            wr_q          <= 1'b0;
            flash_ce_n_o  <= 1'b1;
            flash_oe_n_o  <= 1'b1;
            flash_we_n_o  <= 1'b1;
            flash_addr_o  <= '0;
            flash_dq_o    <= 8'h00;
            flash_dq_oe_o <= 1'b0;
            rdata_o       <= 8'h00;
        end else if (ce_i) begin
            case (cst_q)
                C_IDLE: begin
                    if (start_i) begin
                        flash_addr_o  <= addr_i;
                        flash_dq_o    <= wdata_i;
                        wr_q          <= we_i;
                        flash_dq_oe_o <= we_i;
                        flash_ce_n_o  <= 1'b0;
                        cst_q         <= C_SETUP;
                    end
                end
                C_SETUP: begin
                    cnt_q        <= wr_q ? 4'(WP_CYC - 1) : 4'(ACC_CYC - 1);
                    flash_oe_n_o <= wr_q;
                    flash_we_n_o <= !wr_q;
                    cst_q        <= C_STRB;
                end
                C_STRB: begin
                    if (cnt_q == 4'h0) begin
                        if (!wr_q) begin
                            rdata_o <= flash_dq_i;
                        end
                        flash_oe_n_o <= 1'b1;
                        flash_we_n_o <= 1'b1;
                        cst_q        <= C_END;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                C_END: begin
                    flash_ce_n_o  <= 1'b1;
                    flash_dq_oe_o <= 1'b0;
                    cst_q         <= C_IDLE;
                end
                default: begin
                    cst_q <= C_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [hdl/flrc_host.sv]
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module flrc_host import flrc_pkg::*; #(
    parameter int ADDR_W  = 20,
    parameter int ACC_CYC = 3
) (
    // Clock, reset and enable
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // AXI4-Lite slave
    input  wire logic [4:0]        axi_awaddr_i,
    input  wire logic              axi_awvalid_i,
    output logic                   axi_awready_o,
    input  wire logic [31:0]       axi_wdata_i,
    input  wire logic [3:0]        axi_wstrb_i,
    input  wire logic              axi_wvalid_i,
    output logic                   axi_wready_o,
    output logic [1:0]             axi_bresp_o,
    output logic                   axi_bvalid_o,
    input  wire logic              axi_bready_i,
    input  wire logic [4:0]        axi_araddr_i,
    input  wire logic              axi_arvalid_i,
    output logic                   axi_arready_o,
    output logic [31:0]            axi_rdata_o,
    output logic [1:0]             axi_rresp_o,
    output logic                   axi_rvalid_o,
    input  wire logic              axi_rready_i,
    // Flash pins
    output logic                   flash_ce_n_o,
    output logic                   flash_oe_n_o,
    output logic                   flash_we_n_o,
    output logic [ADDR_W-1:0]      flash_addr_o,
    input  wire logic [7:0]        flash_dq_i,
    output logic [7:0]             flash_dq_o,
    output logic                   flash_dq_oe_o,
    output logic                   flash_clear_n_o,
    output logic                   flash_clear_hv_o,
    input  wire logic              done_flag_pin_i
);
    if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad
        $error("flrc_host: ADDR_W must be 7 to 32");
    end

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_CYC   = 8'h02,
        ST_BUSY  = 8'h04,
        ST_WAIT  = 8'h08,
        ST_CLR   = 8'h10,
        ST_REL   = 8'h20,
        ST_HV    = 8'h40,
        ST_POLL  = 8'h80
    } flrc_st_e;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [4:0] a);
        return a == REG_CTRL || a == REG_ADDR || a == REG_WDATA ||
               a == REG_STAT || a == REG_RDATA;
    endfunction

    // AXI write side: address and data are held apart until both are in.
    logic              aw_hold_q;
    logic              w_hold_q;
    logic [4:0]        awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              aw_take;
    logic              w_take;
    logic              wr_fire;
    logic [4:0]        wa;
    logic [31:0]       wd;
    logic [3:0]        ws;

    assign axi_awready_o = !aw_hold_q && !axi_bvalid_o;
    assign axi_wready_o  = !w_hold_q && !axi_bvalid_o;
    assign aw_take = axi_awvalid_i && axi_awready_o;
    assign w_take  = axi_wvalid_i && axi_wready_o;
    assign wr_fire = (aw_hold_q || aw_take) && (w_hold_q || w_take);
    assign wa = aw_hold_q ? awaddr_q : axi_awaddr_i;
    assign wd = w_hold_q ? wdata_q : axi_wdata_i;
    assign ws = w_hold_q ? wstrb_q : axi_wstrb_i;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            awaddr_q     <= 5'h00;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            axi_bvalid_o <= 1'b0;
            axi_bresp_o  <= RESP_OKAY;
        end else if (ce_i) begin
            if (wr_fire) begin
                aw_hold_q    <= 1'b0;
                w_hold_q     <= 1'b0;
                axi_bvalid_o <= 1'b1;
                axi_bresp_o  <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_hold_q <= 1'b1;
                    awaddr_q  <= axi_awaddr_i;
                end
                if (w_take) begin
                    w_hold_q <= 1'b1;
                    wdata_q  <= axi_wdata_i;
                    wstrb_q  <= axi_wstrb_i;
                end
                if (axi_bvalid_o && axi_bready_i) begin
                    axi_bvalid_o <= 1'b0;
                end
            end
        end
    end

    // Software registers.
    flrc_op_e          op_q;
    logic              unprot_q;
    logic [ADDR_W-1:0] faddr_q;
    logic [7:0]        fwdata_q;
    logic              go_q;
    logic [31:0]       ctrl_rd;
    logic [31:0]       ctrl_m;
    logic [31:0]       addr_m;
    logic [31:0]       wdat_m;

    assign ctrl_rd = {27'h0, unprot_q, op_q, 1'b0};
    assign ctrl_m  = be_merge(ctrl_rd, wd, ws);
    assign addr_m  = be_merge(32'(faddr_q), wd, ws);
    assign wdat_m  = be_merge({24'h0, fwdata_q}, wd, ws);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            op_q     <= OP_READ;
            unprot_q <= 1'b0;
            faddr_q  <= '0;
            fwdata_q <= 8'h00;
            go_q     <= 1'b0;
        end else if (ce_i) begin
            go_q <= wr_fire && wa == REG_CTRL && ws[0] && wd[CTRL_GO];
            if (wr_fire && wa == REG_CTRL) begin
                op_q     <= flrc_op_e'(ctrl_m[CTRL_OP_LSB +: 3]);
                unprot_q <= ctrl_m[CTRL_UNPROT];
            end
            if (wr_fire && wa == REG_ADDR) begin
                faddr_q <= addr_m[ADDR_W-1:0];
            end
            if (wr_fire && wa == REG_WDATA) begin
                fwdata_q <= wdat_m[7:0];
            end
        end
    end

    // Sequencer.
    flrc_st_e          st_q;
    logic [TMR_W-1:0]  tmr_q;
    logic              first_q;
    logic [7:0]        prev_q;
    logic [7:0]        rdata_q;
    logic              settled_q;
    logic              sustog_q;
    logic              cyc_start;
    logic              cyc_we;
    logic              cyc_done;
    logic [7:0]        cyc_rd;
    logic [ADDR_W-1:0] cyc_addr;
    logic              tmr_end;

    assign tmr_end   = (tmr_q == '0);
    assign cyc_we    = !(op_q == OP_READ || op_q == OP_POLL);
    assign cyc_start = (st_q == ST_POLL) ||
                       (st_q == ST_IDLE && go_q &&
                        (op_q == OP_READ || op_q == OP_WRITE ||
                         op_q == OP_PROG || op_q == OP_PROT ||
                         op_q == OP_POLL));
    always_comb begin
        cyc_addr = faddr_q;
        if (op_q == OP_PROT) begin
            cyc_addr[PROT_BIT6] = unprot_q;
            cyc_addr[PROT_BIT1] = 1'b1;
            cyc_addr[PROT_BIT0] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st_q             <= ST_IDLE;
            tmr_q            <= '0;
            flash_clear_n_o  <= 1'b1;
            flash_clear_hv_o <= 1'b0;
            first_q          <= 1'b1;
            prev_q           <= 8'h00;
            rdata_q          <= 8'h00;
            settled_q        <= 1'b0;
            sustog_q         <= 1'b0;
        end else if (ce_i) begin
            if (!tmr_end) begin
                tmr_q <= tmr_q - 1'b1;
            end
            case (st_q)
                ST_IDLE: begin
                    if (go_q) begin
                        first_q <= 1'b1;
                        case (op_q)
                            OP_CLEAR: begin
                                // A busy device needs the long wait, and
                                // the clear aborts its algorithm.
                                flash_clear_n_o <= 1'b0;
                                tmr_q <= done_flag_pin_i ?
                                    TMR_W'(RDY_IDLE_CYC - 1) :
                                    TMR_W'(RDY_ALG_CYC - 1);
                                st_q <= ST_CLR;
                            end
                            OP_HV_ON: begin
                                flash_clear_hv_o <= 1'b1;
                                tmr_q <= TMR_W'(HV_SETUP_CYC - 1);
                                st_q  <= ST_HV;
                            end
                            OP_HV_OFF: begin
                                flash_clear_hv_o <= 1'b0;
                            end
                            OP_POLL: begin
                                settled_q <= 1'b0;
                                st_q      <= ST_CYC;
                            end
                            default: begin
                                st_q <= ST_CYC;
                            end
                        endcase
                    end
                end
                ST_CYC: begin
                    if (cyc_done) begin
                        rdata_q <= cyc_rd;
                        if (op_q == OP_POLL) begin
                            prev_q  <= cyc_rd;
                            first_q <= 1'b0;
                            if (!first_q) begin
                                sustog_q <= cyc_rd[SUS_BIT] ^ prev_q[SUS_BIT];
                            end
                            if (!first_q &&
                                cyc_rd[TOG_BIT] == prev_q[TOG_BIT]) begin
                                settled_q <= 1'b1;
                                st_q      <= ST_IDLE;
                            end else begin
                                st_q <= ST_POLL;
                            end
                        end else if (op_q == OP_PROG) begin
                            tmr_q <= TMR_W'(BUSY_DLY_CYC - 1);
                            st_q  <= ST_BUSY;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_POLL: begin
                    st_q <= ST_CYC;
                end
                ST_BUSY: begin
                    if (tmr_end) begin
                        st_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (done_flag_pin_i) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_CLR: begin
                    if (tmr_end) begin
                        flash_clear_n_o <= 1'b1;
                        tmr_q <= TMR_W'(REL_READ_CYC - 1);
                        st_q  <= ST_REL;
                    end
                end
                ST_REL, ST_HV: begin
                    if (tmr_end) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    flrc_cycle #(
        .ADDR_W  (ADDR_W),
        .ACC_CYC (ACC_CYC),
        .WP_CYC  (1)
    ) u_cycle (
        .clk_sys_i     (clk_sys_i),
        .rst_i         (rst_i),
        .ce_i          (ce_i),
        .start_i       (cyc_start),
        .we_i          (cyc_we),
        .addr_i        (cyc_addr),
        .wdata_i       (fwdata_q),
        .done_o        (cyc_done),
        .rdata_o       (cyc_rd),
        .flash_ce_n_o  (flash_ce_n_o),
        .flash_oe_n_o  (flash_oe_n_o),
        .flash_we_n_o  (flash_we_n_o),
        .flash_addr_o  (flash_addr_o),
        .flash_dq_i    (flash_dq_i),
        .flash_dq_o    (flash_dq_o),
        .flash_dq_oe_o (flash_dq_oe_o)
    );

    // AXI read side.
    logic [31:0] stat_rd;
    assign stat_rd = {27'h0, sustog_q, settled_q, flash_clear_hv_o,
                      done_flag_pin_i, st_q != ST_IDLE};
    assign axi_arready_o = !axi_rvalid_o;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            axi_rvalid_o <= 1'b0;
            axi_rdata_o  <= 32'h0000_0000;
            axi_rresp_o  <= RESP_OKAY;
        end else if (ce_i) begin
            if (axi_arvalid_i && axi_arready_o) begin
                axi_rvalid_o <= 1'b1;
                axi_rresp_o  <= mapped(axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
                case (axi_araddr_i)
                    REG_CTRL:  axi_rdata_o <= ctrl_rd;
                    REG_ADDR:  axi_rdata_o <= 32'(faddr_q);
                    REG_WDATA: axi_rdata_o <= {24'h0, fwdata_q};
                    REG_STAT:  axi_rdata_o <= stat_rd;
                    REG_RDATA: axi_rdata_o <= {24'h0, rdata_q};
                    default:   axi_rdata_o <= 32'h0000_0000;
                endcase
            end else if (axi_rvalid_o && axi_rready_i) begin
                axi_rvalid_o <= 1'b0;
            end
        end
    end

    // Helper counters for the checks below; saturating.
    logic [2:0] rel_cnt_q;
    logic [6:0] hv_cnt_q;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rel_cnt_q <= 3'h0;
            hv_cnt_q  <= 7'h00;
        end else if (ce_i) begin
            if (!flash_clear_n_o) rel_cnt_q <= 3'h0;
            else if (rel_cnt_q != 3'h7) rel_cnt_q <= rel_cnt_q + 3'h1;
            if (!flash_clear_hv_o) hv_cnt_q <= 7'h00;
            else if (hv_cnt_q != 7'h7F) hv_cnt_q <= hv_cnt_q + 7'h01;
        end
    end

    sequence s_clear_release;
        !flash_clear_n_o ##1 flash_clear_n_o;
    endsequence

    chk_release_quiet: assert property (
        @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
        s_clear_release |-> flash_oe_n_o && flash_ce_n_o)
        else $error("read strobe in the clear release cycle");

    chk_read_after_rel: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !flash_oe_n_o |-> rel_cnt_q >= 3'(REL_READ_CYC))
        else $error("read too soon after clear release");

    chk_hv_before_wr: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        flash_clear_hv_o && !flash_we_n_o |-> hv_cnt_q >= 7'(HV_SETUP_CYC))
        else $error("write before elevated setup time");

    chk_prot_addr: assert property (
        @(posedge clk_sys_i) disable iff (rst_i)
        !flash_we_n_o && op_q == OP_PROT |->
            flash_addr_o[PROT_BIT6] == unprot_q &&
            flash_addr_o[PROT_BIT1:PROT_BIT0] == 2'b10)
        else $error("protect address bits wrong");

    chk_poll_gap: assert property (
        @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
        st_q == ST_POLL |-> flash_oe_n_o && flash_ce_n_o ##1 cyc_start == 1'b0)
        else $error("status reads not separated");

    chk_ready_resume: assert property (
        @(posedge clk_sys_i) disable iff (rst_i || !ce_i)
        $rose(st_q == ST_BUSY) |-> (st_q == ST_BUSY)[*2] ##1
            (st_q == ST_WAIT || st_q == ST_IDLE))
        else $error("busy delay wrong length");
endmodule
`default_nettype wire

// [sim/flrc_dev_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Busy time is far shorter than a real program so runs stay brief.
module flrc_dev_model #(
    parameter int BUSY_CYC = 60
) (
    input  wire logic        clk_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        clear_n_i,
    input  wire logic [19:0] addr_i,
    input  wire logic [7:0]  dq_i,
    input  wire logic        dq_oe_i,
    output logic [7:0]       dq_o,
    output logic             ready_o,
    output logic [19:0]      wr_addr_o
);
    logic [7:0] mem [256];
    int         cnt = 0;
    logic       tog = 1'b0;
    always @(posedge clk_i) begin
        if (!clear_n_i) begin
            cnt <= 0;
        end else if (!ce_n_i && !we_n_i) begin
            // Undriven data lands inverted, so a missing enable shows up.
            mem[addr_i[7:0]] <= dq_oe_i ? dq_i : ~dq_i;
            wr_addr_o        <= addr_i;
            cnt              <= BUSY_CYC;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    always @(negedge oe_n_i) begin
        if (cnt > 0) begin
            tog <= !tog;
        end
    end
    assign ready_o = (cnt == 0);
    // A released bus shows the complement, so stale data never matches.
    assign dq_o = (ce_n_i || oe_n_i) ? ~mem[addr_i[7:0]] :
    // No sector is erase-suspended, so the suspend bit holds still.
                  (cnt > 0) ? {1'b0, tog, 3'h0, mem[addr_i[7:0]][2], 2'h0} :
                  mem[addr_i[7:0]];
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import flrc_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic        awr, wrr, bv, arr, rv, ce_n, oe_n, we_n, clr_n, rdy, dqoe;
    logic [4:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rdd, last;
    logic [1:0]  br, rr, b_q[$];
    logic [19:0] fa, wa, a;
    logic [7:0]  dqh, dqd, d;
    logic [33:0] exp_q[$], msk_q[$];
    int          errors = 0, check_count = 0, low = 0;
    flrc_host flrc_host_i (
        .clk_sys_i, .rst_i, .ce_i(1'b1), .axi_awaddr_i(awa),
        .axi_awvalid_i(awv), .axi_awready_o(awr), .axi_wdata_i(wd),
        .axi_wstrb_i(4'hf), .axi_wvalid_i(wv), .axi_wready_o(wrr),
        .axi_bresp_o(br), .axi_bvalid_o(bv), .axi_bready_i(bry),
        .axi_araddr_i(ara), .axi_arvalid_i(arv), .axi_arready_o(arr),
        .axi_rdata_o(rdd), .axi_rresp_o(rr), .axi_rvalid_o(rv),
        .axi_rready_i(rry), .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n),
        .flash_we_n_o(we_n), .flash_addr_o(fa), .flash_dq_i(dqd),
        .flash_dq_o(dqh), .flash_dq_oe_o(dqoe), .flash_clear_n_o(clr_n),
        .flash_clear_hv_o(), .done_flag_pin_i(rdy));
    flrc_dev_model flrc_dev_model_i (.clk_i(clk_sys_i), .ce_n_i(ce_n),
        .oe_n_i(oe_n), .we_n_i(we_n), .clear_n_i(clr_n), .addr_i(fa),
        .dq_i(dqh), .dq_oe_i(dqoe), .dq_o(dqd), .ready_o(rdy),
        .wr_addr_o(wa));
    function automatic logic [1:0] resp(input logic [4:0] x);
        return (x > REG_RDATA) ? RESP_SLVERR : RESP_OKAY;
    endfunction
    task automatic cmp(input logic [33:0] got, exp, msk);
        check_count++;
        if ((got & msk) !== (exp & msk)) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [4:0] x, input logic [31:0] v);
        @(posedge clk_sys_i);
        b_q.push_back(resp(x));
        awa <= x;
        wd  <= v;
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (awr) awv <= 1'b0;
            if (wrr) wv <= 1'b0;
        end while (!bv);
        bry <= 1'b0;
    endtask
    task automatic axr(input logic [4:0] x, input logic [31:0] e, m);
        @(posedge clk_sys_i);
        exp_q.push_back({resp(x), e});
        msk_q.push_back({2'h3, m});
        ara <= x;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (arr) arv <= 1'b0;
        end while (!rv);
        last = rdd;
        rry <= 1'b0;
    endtask
    task automatic go(input logic [3:0] op);
        axw(REG_CTRL, {27'h0, op, 1'b1});
        repeat (3) @(posedge clk_sys_i);
        last = 32'h1;
        for (int i = 0; i < 500 && last[STAT_BUSY]; i++) axr(REG_STAT, 0, 0);
        cmp(last, 34'h0, 34'h1);
    endtask
    task automatic finish_test;
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        if (!clr_n) low++;
        if (rv && rry) cmp({rr, rdd}, exp_q.pop_front(), msk_q.pop_front());
        if (bv && bry) cmp({br, 32'h0}, {b_q.pop_front(), 32'h0}, '1);
    end
    initial forever #25 clk_sys_i = ~clk_sys_i;
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        errors++;
        finish_test;
    end
    initial begin
        void'($urandom(32'h7753));
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        axr(5'h14, 32'h0, 32'hffff_ffff);
        axw(5'h14, 32'h0);
        for (int k = 0; k < 3; k++) begin
            a = 20'($urandom);
            d = 8'($urandom);
            axw(REG_ADDR, {12'h0, a});
            axw(REG_WDATA, {24'h0, d});
            go({1'b0, OP_PROG});
            axr(REG_STAT, 32'h2, 32'h3);
            go({1'b0, OP_READ});
            axr(REG_RDATA, {24'h0, d}, 32'hff);
        end
        for (int u = 0; u < 2; u++) begin
            go({u[0], OP_PROT});
            cmp(wa, {a[19:7], u[0], a[5:2], 2'b10}, '1);
        end
        go({1'b0, OP_WRITE});
        low = 0;
        go({1'b0, OP_CLEAR});
        cmp(low, RDY_ALG_CYC, '1);
        axr(REG_STAT, 32'h2, 32'h3);
        low = 0;
        go({1'b0, OP_CLEAR});
        cmp(low, RDY_IDLE_CYC, '1);
        go({1'b0, OP_WRITE});
        go({1'b0, OP_POLL});
        axr(REG_STAT, 32'h8, 32'h18);
        go({1'b0, OP_HV_ON});
        axr(REG_STAT, 32'h4, 32'h4);
        go({1'b0, OP_WRITE});
        go({1'b0, OP_HV_OFF});
        axr(REG_STAT, 32'h0, 32'h4);
        finish_test;
    end
endmodule
`default_nettype wire
